// File: core/cctpa_timer.sv
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
module cctpa_timer
    import cctpa_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cctpa_pkg::ADDR_W-1:0] paddr,
    input wire logic [cctpa_pkg::DATA_W-1:0] pwdata,
    output logic pready,
    output logic [cctpa_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    input wire logic [cctpa_pkg::NUM_CH-1:0] chanPinIn,
    output logic [cctpa_pkg::NUM_CH-1:0] chanPinOut,
    output logic [cctpa_pkg::NUM_CH-1:0] chanPinOe,
    output logic [cctpa_pkg::NUM_CH-1:0] chanIrq,
    output logic accumInIrq,
    output logic accumOvfIrq,
    output logic ovfIrq
);
    // Configuration
    logic [NUM_CH-1:0] dirSel, cmpMode, cmpLevel, oc7Mask, oc7Data;
    logic [NUM_CH-1:0] chanIrqEn, portLatch, portDir;
    logic [2*NUM_CH-1:0] capEdge;
    logic timerEn, fastClr, ovfIrqEn, cntRstEn;
    logic [PS_W-1:0] prescaleSel;
    logic accEn, accMode, accEdge, accOvfIrqEn, accInIrqEn;
    // State
    logic [NUM_CH-1:0] chanFlag, ocState;
    logic ovfFlag, accOvfFlag, accInFlag, cntMoved;
    logic [CNT_W-1:0] freeCnt, accumCnt;
    logic [CNT_W-1:0] chanReg [NUM_CH];
    logic [NUM_CH-1:0] pinSync, pinLast;
    // Events
    logic cntTick, div64Tick, ch7Reset;
    logic [NUM_CH-1:0] match, capEvt, forceCmp, connected;
    logic evtEdge, gatedInc, trailing, accInc, gateOn, gateWas;
    logic access, wrEn, accWr, mapped;
    logic [DATA_W-1:0] rdMux;

    // Address decode helpers, used by write and read paths
    function automatic logic isReg(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] ofs);
        isReg = (a == ofs);
    endfunction : isReg

    function automatic logic isChan(input logic [ADDR_W-1:0] a);
        isChan = (a >= OFS_CHBASE) && (a <= OFS_CHEND) && (a[1:0] == 2'b00);
    endfunction : isChan

    // Edge of the chosen kind between last and current sample
    function automatic logic edgeHit(input logic [1:0] sel,
                                     input logic prev,
                                     input logic cur);
        edgeHit = (sel[0] && !prev && cur) || (sel[1] && prev && !cur);
    endfunction : edgeHit

    // New pin level for one compare action
    function automatic logic ocNext(input logic [1:0] act,
                                    input logic cur);
        case (cctpa_ocact_t'(act))
            OC_TOGGLE: ocNext = !cur;
            OC_CLEAR: ocNext = 1'b0;
            OC_SET: ocNext = 1'b1;
            default: ocNext = cur;
        endcase
    endfunction : ocNext

    // Zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign access = psel && penable;
    assign wrEn = access && pwrite;
    assign accWr = wrEn && isReg(paddr, OFS_ACCCNT);

    cctpa_sync #(
        .W(NUM_CH)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn(chanPinIn),
        .syncOut(pinSync)
    );

    cctpa_prescale u_pre (
        .clk(clk),
        .sys_rst(sys_rst),
        .enable(timerEn),
        .prescaleSel(prescaleSel),
        .cntTick(cntTick),
        .div64Tick(div64Tick)
    );

    // Previous synchronised level, for edge detection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinLast <= '0;
        end else begin
            pinLast <= pinSync;
        end
    end

    // Software-written configuration
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dirSel <= '0;
            cmpMode <= '0;
            cmpLevel <= '0;
            oc7Mask <= '0;
            oc7Data <= '0;
            chanIrqEn <= '0;
            portLatch <= '0;
            portDir <= '0;
            capEdge <= '0;
            timerEn <= 1'b0;
            fastClr <= 1'b0;
            ovfIrqEn <= 1'b0;
            cntRstEn <= 1'b0;
            prescaleSel <= '0;
            {accEn, accMode, accEdge, accOvfIrqEn, accInIrqEn} <= '0;
        end else if (wrEn) begin
            if (isReg(paddr, OFS_DIR)) dirSel <= pwdata[NUM_CH-1:0];
            if (isReg(paddr, OFS_OC7MASK)) oc7Mask <= pwdata[NUM_CH-1:0];
            if (isReg(paddr, OFS_OC7DATA)) oc7Data <= pwdata[NUM_CH-1:0];
            if (isReg(paddr, OFS_IRQEN)) chanIrqEn <= pwdata[NUM_CH-1:0];
            if (isReg(paddr, OFS_PORT)) portLatch <= pwdata[NUM_CH-1:0];
            if (isReg(paddr, OFS_PORTDIR)) portDir <= pwdata[NUM_CH-1:0];
            if (isReg(paddr, OFS_CAPEDGE)) capEdge <= pwdata[2*NUM_CH-1:0];
            if (isReg(paddr, OFS_OUTMODE)) begin
                cmpMode <= pwdata[NUM_CH-1:0];
                cmpLevel <= pwdata[LEVEL_LSB +: NUM_CH];
            end
            if (isReg(paddr, OFS_SYSCTL1)) begin
                timerEn <= pwdata[TEN_BIT];
                fastClr <= pwdata[FFCA_BIT];
            end
            if (isReg(paddr, OFS_SYSCTL2)) begin
                ovfIrqEn <= pwdata[TOI_BIT];
                cntRstEn <= pwdata[COUNTER_RESET_ON_CH7_ENABLE_BIT];
                prescaleSel <= pwdata[PS_W-1:0];
            end
            if (isReg(paddr, OFS_ACCCTL)) begin
                accEn <= pwdata[ACC_EN_BIT];
                accMode <= pwdata[ACC_MODE_BIT];
                accEdge <= pwdata[ACC_EDGE_BIT];
                accOvfIrqEn <= pwdata[ACC_OVI_BIT];
                accInIrqEn <= pwdata[ACC_II_BIT];
            end
        end
    end

    assign ch7Reset = cntMoved && cntRstEn && (freeCnt == chanReg[NUM_CH-1])
                      && (chanReg[NUM_CH-1] != CNT_ZERO);

    // Counter; the top value lasts one cycle because reset follows it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            freeCnt <= CNT_ZERO;
            cntMoved <= 1'b0;
        end else begin
            cntMoved <= 1'b0;
            if (ch7Reset) begin
                freeCnt <= CNT_ZERO;
                cntMoved <= 1'b1;
            end else if (cntTick) begin
                freeCnt <= freeCnt + 16'h0001;
                cntMoved <= 1'b1;
            end
        end
    end

    // Per-channel events; matches only on a freshly loaded counter value
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            match[i] = dirSel[i] && cntMoved && (freeCnt == chanReg[i]);
            capEvt[i] = !dirSel[i] && edgeHit(capEdge[2*i +: 2], pinLast[i],
                                              pinSync[i]);
            connected[i] = dirSel[i] && ((cmpMode[i] || cmpLevel[i])
                                         || oc7Mask[i]);
        end
    end
    assign forceCmp = (wrEn && isReg(paddr, OFS_FORCE)) ? pwdata[NUM_CH-1:0]
                                                         : '0;

    // Channel registers: capture beats a software write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_CH; i++) chanReg[i] <= CNT_ZERO;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (capEvt[i]) begin
                    chanReg[i] <= freeCnt;
                end else if (wrEn && isChan(paddr) && (paddr[4:2] == 3'(i)))
                begin
                    chanReg[i] <= pwdata[CNT_W-1:0];
                end
            end
        end
    end

    // Channel flags: a set in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chanFlag <= '0;
        end else begin
            chanFlag <= (chanFlag & ~((wrEn && timerEn
                          && isReg(paddr, OFS_FLAG1)) ? pwdata[NUM_CH-1:0]
                          : '0)) | capEvt | match;
        end
    end

    // Compare pin state; channel 7 is applied last so it overrides
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ocState <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (dirSel[i] && (match[i] || forceCmp[i])) begin
                    ocState[i] <= ocNext({cmpMode[i], cmpLevel[i]},
                                         ocState[i]);
                end
            end
            if (dirSel[NUM_CH-1] && (match[NUM_CH-1] || forceCmp[NUM_CH-1]))
            begin
                for (int i = 0; i < NUM_CH; i++) begin
                    if (oc7Mask[i]) ocState[i] <= oc7Data[i];
                end
            end
        end
    end

    // Pin drive; the latch shows once the compare logic lets go
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chanPinOut <= '0;
            chanPinOe <= '0;
        end else begin
            chanPinOut <= (connected & ocState) | (~connected & portLatch);
            chanPinOe <= connected | portDir;
        end
    end

    // Accumulator events on the shared channel 7 pin
    assign gateOn = pinSync[NUM_CH-1] ^ accEdge;
    assign gateWas = pinLast[NUM_CH-1] ^ accEdge;
    assign evtEdge = accEn && !accMode && (accEdge
                     ? (!pinLast[NUM_CH-1] && pinSync[NUM_CH-1])
                     : (pinLast[NUM_CH-1] && !pinSync[NUM_CH-1]));
    assign gatedInc = accEn && accMode && div64Tick && gateOn;
    assign trailing = accEn && accMode && gateWas && !gateOn;
    assign accInc = evtEdge || gatedInc;

    // Accumulator count; a software write takes the cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            accumCnt <= CNT_ZERO;
        end else if (accWr) begin
            accumCnt <= pwdata[CNT_W-1:0];
        end else if (accInc) begin
            accumCnt <= accumCnt + 16'h0001;
        end
    end

    // Accumulator and counter flags; set wins over clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            accOvfFlag <= 1'b0;
            accInFlag <= 1'b0;
            ovfFlag <= 1'b0;
        end else begin
            if (timerEn && ((fastClr && access && isReg(paddr, OFS_ACCCNT))
                || (wrEn && isReg(paddr, OFS_ACCFLG)
                    && pwdata[ACC_OVF_BIT])))
                accOvfFlag <= 1'b0;
            if (timerEn && ((fastClr && access && isReg(paddr, OFS_ACCCNT))
                || (wrEn && isReg(paddr, OFS_ACCFLG)
                    && pwdata[ACC_IF_BIT])))
                accInFlag <= 1'b0;
            if (timerEn && wrEn && isReg(paddr, OFS_FLAG2)
                && pwdata[TOF_BIT])
                ovfFlag <= 1'b0;
            if (accInc && !accWr && (accumCnt == CNT_MAX)) accOvfFlag <= 1'b1;
            if (evtEdge || trailing) accInFlag <= 1'b1;
            if (cntTick && !ch7Reset && (freeCnt == CNT_MAX)) ovfFlag <= 1'b1;
        end
    end

    assign chanIrq = chanFlag & chanIrqEn;
    assign accumInIrq = accInFlag && accInIrqEn;
    assign accumOvfIrq = accOvfFlag && accOvfIrqEn;
    assign ovfIrq = ovfFlag && ovfIrqEn;

    // Read mux; force register reads as zero
    always_comb begin
        rdMux = '0;
        mapped = 1'b1;
        case (paddr)
            OFS_DIR: rdMux[NUM_CH-1:0] = dirSel;
            OFS_FORCE: rdMux = '0;
            OFS_OC7MASK: rdMux[NUM_CH-1:0] = oc7Mask;
            OFS_OC7DATA: rdMux[NUM_CH-1:0] = oc7Data;
            OFS_COUNT: rdMux[CNT_W-1:0] = freeCnt;
            OFS_SYSCTL1: begin
                rdMux[TEN_BIT] = timerEn;
                rdMux[FFCA_BIT] = fastClr;
            end
            OFS_OUTMODE: rdMux[2*NUM_CH-1:0] = {cmpLevel, cmpMode};
            OFS_IRQEN: rdMux[NUM_CH-1:0] = chanIrqEn;
            OFS_SYSCTL2: begin
                rdMux[TOI_BIT] = ovfIrqEn;
                rdMux[COUNTER_RESET_ON_CH7_ENABLE_BIT] = cntRstEn;
                rdMux[PS_W-1:0] = prescaleSel;
            end
            OFS_FLAG1: rdMux[NUM_CH-1:0] = chanFlag;
            OFS_FLAG2: rdMux[TOF_BIT] = ovfFlag;
            OFS_ACCCTL: begin
                rdMux[ACC_EN_BIT] = accEn;
                rdMux[ACC_MODE_BIT] = accMode;
                rdMux[ACC_EDGE_BIT] = accEdge;
                rdMux[ACC_OVI_BIT] = accOvfIrqEn;
                rdMux[ACC_II_BIT] = accInIrqEn;
            end
            OFS_ACCFLG: rdMux[1:0] = {accOvfFlag, accInFlag};
            OFS_ACCCNT: rdMux[CNT_W-1:0] = accumCnt;
            OFS_PORT: rdMux[NUM_CH-1:0] = portLatch;
            OFS_PORTDIR: rdMux[NUM_CH-1:0] = portDir;
            OFS_CAPEDGE: rdMux[2*NUM_CH-1:0] = capEdge;
            default: begin
                if (isChan(paddr)) rdMux[CNT_W-1:0] = chanReg[paddr[4:2]];
                else mapped = 1'b0;
            end
        endcase
    end

    // Read data and error sampled in the setup cycle, held through access
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? '0 : rdMux;
            pslverr <= !mapped;
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_top_reached;
        cntMoved && cntRstEn && (freeCnt == chanReg[NUM_CH-1])
            && (chanReg[NUM_CH-1] != CNT_ZERO);
    endsequence
    sequence s_back_to_zero;
        (freeCnt == CNT_ZERO) && cntMoved;
    endsequence

    a_counter_step: assert property (
        cntTick && !ch7Reset |=> freeCnt == 16'($past(freeCnt) + 16'h0001))
        else $error("counter did not step on tick");
    a_capture_copy: assert property (
        capEvt[0] |=> chanReg[0] == $past(freeCnt))
        else $error("capture value wrong");
    a_capture_flag: assert property (
        capEvt[0] |=> chanFlag[0] && (chanIrq[0] == chanIrqEn[0]))
        else $error("capture flag or request wrong");
    a_compare_flag: assert property (
        match[1] |=> chanFlag[1])
        else $error("compare match did not set flag");
    a_force_noflag: assert property (
        (forceCmp != '0) && (chanFlag == '0) && (match == '0)
            && (capEvt == '0) |=> chanFlag == '0)
        else $error("forced compare set a flag");
    a_top_one_cycle: assert property (
        s_top_reached |=> s_back_to_zero)
        else $error("counter held top value too long");
    a_accum_event: assert property (
        evtEdge && !accWr |=> accumCnt == 16'($past(accumCnt) + 16'h0001))
        else $error("event edge not counted");
    a_accum_wrap: assert property (
        accInc && !accWr && (accumCnt == CNT_MAX)
            |=> accOvfFlag && (accumCnt == CNT_ZERO))
        else $error("accumulator wrap lost");
    a_gate_stopped: assert property (
        accMode && !timerEn && !accWr |=> $stable(accumCnt))
        else $error("gated count advanced with timer off");
    a_ovf_flag: assert property (
        cntTick && !ch7Reset && (freeCnt == CNT_MAX)
            |=> ovfFlag && (freeCnt == CNT_ZERO))
        else $error("counter wrap flag missing");
endmodule : cctpa_timer

// File: core/cctpa_pkg.sv
package cctpa_pkg;
    // Geometry
    localparam int NUM_CH = 8;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PS_W = 3;
    localparam int PRE_W = 7;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFS_DIR = 8'h00;
    localparam logic [7:0] OFS_FORCE = 8'h04;
    localparam logic [7:0] OFS_OC7MASK = 8'h08;
    localparam logic [7:0] OFS_OC7DATA = 8'h0C;
    localparam logic [7:0] OFS_COUNT = 8'h10;
    localparam logic [7:0] OFS_SYSCTL1 = 8'h14;
    localparam logic [7:0] OFS_OUTMODE = 8'h18;
    localparam logic [7:0] OFS_IRQEN = 8'h1C;
    localparam logic [7:0] OFS_SYSCTL2 = 8'h20;
    localparam logic [7:0] OFS_FLAG1 = 8'h24;
    localparam logic [7:0] OFS_FLAG2 = 8'h28;
    localparam logic [7:0] OFS_ACCCTL = 8'h2C;
    localparam logic [7:0] OFS_ACCFLG = 8'h30;
    localparam logic [7:0] OFS_ACCCNT = 8'h34;
    localparam logic [7:0] OFS_PORT = 8'h38;
    localparam logic [7:0] OFS_PORTDIR = 8'h3C;
    localparam logic [7:0] OFS_CAPEDGE = 8'h40;
    localparam logic [7:0] OFS_CHBASE = 8'h60;
    localparam logic [7:0] OFS_CHEND = 8'h7C;

    // Field positions
    localparam int TEN_BIT = 7;
    localparam int FFCA_BIT = 4;
    localparam int TOI_BIT = 7;
    localparam int COUNTER_RESET_ON_CH7_ENABLE_BIT = 3;
    localparam int TOF_BIT = 7;
    localparam int LEVEL_LSB = 8;
    localparam int ACC_EN_BIT = 6;
    localparam int ACC_MODE_BIT = 5;
    localparam int ACC_EDGE_BIT = 4;
    localparam int ACC_OVI_BIT = 1;
    localparam int ACC_II_BIT = 0;
    localparam int ACC_OVF_BIT = 1;
    localparam int ACC_IF_BIT = 0;

    // Values
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [5:0] DIV64_MASK = 6'h3F;

    // Compare action, {mode, level}
    typedef enum logic [1:0] {
        OC_NONE = 2'b00,
        OC_TOGGLE = 2'b01,
        OC_CLEAR = 2'b10,
        OC_SET = 2'b11
    } cctpa_ocact_t;

    // Capture edge choice per channel
    typedef enum logic [1:0] {
        EDGE_OFF = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } cctpa_edge_t;
endpackage : cctpa_pkg

// File: core/cctpa_sync.sv
`timescale 1ns/10ps
module cctpa_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] stageOne;

    // Two flops; the first is read only by the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stageOne <= '0;
            syncOut <= '0;
        end else begin
            stageOne <= asyncIn;
            syncOut <= stageOne;
        end
    end
endmodule : cctpa_sync

// File: core/cctpa_prescale.sv
`timescale 1ns/10ps
module cctpa_prescale
    import cctpa_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic [cctpa_pkg::PS_W-1:0] prescaleSel,
    output logic cntTick,
    output logic div64Tick
);
    logic [PRE_W-1:0] preCnt;
    logic [PRE_W-1:0] divMask;

    // Held at zero while the timer is off, so no tick of either kind
    always_ff @(posedge clk) begin
        if (sys_rst || !enable) begin
            preCnt <= '0;
        end else begin
            preCnt <= preCnt + 7'h01;
        end
    end

    // Divisor 2^sel: tick when the low sel bits are all ones
    assign divMask = PRE_W'((8'h01 << prescaleSel) - 8'h01);
    assign cntTick = enable && ((preCnt & divMask) == divMask);
    assign div64Tick = enable && (preCnt[5:0] == DIV64_MASK);
endmodule : cctpa_prescale

// File: verif/cctpa_pin_model.sv
`timescale 1ns/10ps
module cctpa_pin_model (
    input wire logic clk,
    output logic [7:0] pins
);
    // Pins rest low, as if pulled down
    initial pins = 8'h00;
    task automatic pulse(input int ch, input int n);
        @(posedge clk);
        pins[ch] <= 1'b1;
        repeat (n) @(posedge clk);
        pins[ch] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : pulse
endmodule : cctpa_pin_model

// File: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
    import cctpa_pkg::*;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, pinIn, pinOut, pinOe, chIrq;
    logic [31:0] pwdata, prdata, q, c;
    logic accIn, accOvf, ovf;
    int nErrors = 0, nTests = 0;
    cctpa_timer dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .chanPinIn(pinIn), .chanPinOut(pinOut),
        .chanPinOe(pinOe), .chanIrq(chIrq), .accumInIrq(accIn),
        .accumOvfIrq(accOvf), .ovfIrq(ovf));
    cctpa_pin_model pm (.clk(clk), .pins(pinIn));
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    task automatic give_verdict;
        $display("checks %0d errors %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask : chk
    // APB transfer, waits on pready under a bound
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        int k;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            nErrors++;
            give_verdict();
        end
        r = prdata;
        psel <= 1'b0; penable <= 1'b0;
        // One idle edge, so no signal is driven twice in a time step
        @(posedge clk);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0, q);
    endtask : rd
    initial begin
        #2000000;
        nErrors++;
        give_verdict();
    end
    initial begin
        logic [15:0] act;
        logic expv;
        sys_rst = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0;
        repeat (20) @(posedge clk);
        sys_rst <= 0;
        repeat (2) @(posedge clk);
        rd(8'hF0); chk(pslverr, 1);
        wr(OFS_SYSCTL1, 32'h80); wr(OFS_CAPEDGE, 32'h1);
        pm.pulse(0, 4); rd(OFS_FLAG1); chk(q, 1);
        chk(chIrq, 0); wr(OFS_IRQEN, 1); chk(chIrq, 1);
        rd(OFS_CHBASE); c = q; rd(OFS_COUNT);
        chk(c != 0 && c < q, 1);
        wr(OFS_FLAG1, 1); rd(OFS_FLAG1); chk(q, 0);
        wr(OFS_DIR, 2);
        for (int i = 0; i < 3; i++) begin
            // Set, then clear, then toggle from low
            act = (i == 0) ? 16'h0202 : ((i == 1) ? 16'h0002 : 16'h0200);
            expv = (i != 1);
            wr(OFS_OUTMODE, act); wr(OFS_FORCE, 2);
            repeat (3) @(posedge clk);
            chk(pinOut[1], expv);
        end
        rd(OFS_FLAG1); chk(q, 0);
        wr(OFS_PORT, 0); wr(OFS_PORTDIR, 2);
        chk(pinOut[1], 1);
        wr(OFS_OUTMODE, 0); repeat (3) @(posedge clk);
        chk({pinOut[1], pinOe[1]}, 2'b01);
        // Second reset brings the counter back below the channel 7 top
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        wr(OFS_CHBASE + 8'h1C, 5); wr(OFS_SYSCTL2, 8); wr(OFS_DIR, 32'h82);
        wr(OFS_OC7MASK, 2); wr(OFS_OC7DATA, 2); wr(OFS_SYSCTL1, 32'h80);
        repeat (6) begin
            rd(OFS_COUNT); chk(q <= 5, 1);
        end
        rd(OFS_FLAG1); chk(q, 32'h82);
        chk(pinOut[1], 1);
        wr(OFS_SYSCTL2, 0); wr(OFS_SYSCTL1, 0);
        wr(OFS_OC7MASK, 0); wr(OFS_DIR, 0);
        wr(OFS_ACCCTL, 32'h50);
        repeat (3) pm.pulse(7, 4);
        rd(OFS_ACCCNT); chk(q, 3);
        wr(OFS_ACCCNT, 32'hFFFF); wr(OFS_ACCCTL, 32'h52);
        pm.pulse(7, 4); rd(OFS_ACCCNT); chk(q, 0);
        chk(accOvf, 1);
        wr(OFS_SYSCTL1, 32'h80); wr(OFS_ACCFLG, 3);
        wr(OFS_ACCCTL, 32'h61); wr(OFS_ACCCNT, 0);
        chk({accIn, accOvf}, 0);
        pm.pulse(7, 200); rd(OFS_ACCCNT);
        chk(q >= 2 && q <= 4, 1);
        chk(accIn, 1);
        wr(OFS_SYSCTL1, 32'h90); rd(OFS_ACCCNT); c = q;
        rd(OFS_ACCFLG); chk(q, 0);
        wr(OFS_SYSCTL1, 0); pm.pulse(7, 150);
        rd(OFS_ACCCNT); chk(q, c);
        give_verdict();
    end
endmodule : testbench
